// ---- inc/srplm_pkg.sv ----
// Package for the per-port link maintenance register bank.
// Assumes one 32-bit register word per four-byte aligned byte address.
`default_nettype none

package srplm_pkg;
    localparam int ADDR_W = 24;
    localparam int PORT_COUNT = 16;
    localparam logic [23:0] PORT_STRIDE = 24'h00_0020;
    localparam logic [23:0] OFS_LINK_REQ = 24'h00_0140;
    localparam logic [23:0] OFS_LINK_RESP = 24'h00_0144;
    localparam logic [23:0] OFS_ACKID = 24'h00_0148;
    localparam logic [23:0] OFS_ERR_STAT = 24'h00_0158;
    localparam logic [23:0] OFS_PORT_CTRL = 24'h00_015c;
    localparam logic [2:0] CMD_RESET_DEVICE = 3'h3;
    localparam logic [2:0] CMD_INPUT_STATUS = 3'h4;
    localparam int RESP_LINK_LSB = 0;
    localparam int RESP_ACK_LSB = 5;
    localparam int RESP_VALID_BIT = 31;
    localparam int ACK_TX_LSB = 0;
    localparam int ACK_EXP_LSB = 8;
    localparam int ACK_RX_LSB = 24;
    localparam int ACK_DISCARD_BIT = 31;
    localparam int ES_UNINIT_BIT = 0;
    localparam int ES_OK_BIT = 1;
    localparam int ES_ERR_BIT = 2;
    localparam int ES_PW_BIT = 4;
    localparam int ES_IN_ERR_BIT = 8;
    localparam int ES_IN_ERR_SEEN_BIT = 9;
    localparam int ES_IN_RETRY_BIT = 10;
    localparam int ES_OUT_ERR_BIT = 16;
    localparam int ES_OUT_ERR_SEEN_BIT = 17;
    localparam int ES_OUT_RETRY_BIT = 18;
    localparam int ES_OUT_RETRIED_BIT = 19;
    localparam int ES_OUT_RETRY_SEEN_BIT = 20;
    localparam int PC_TYPE_BIT = 0;
    localparam int PC_MASK_LSB = 4;
    localparam int PC_ENUM_BIT = 17;
    localparam int PC_MCAST_BIT = 19;
    localparam int PC_CHK_OFF_BIT = 20;
    localparam int PC_IN_EN_BIT = 21;
    localparam int PC_OUT_EN_BIT = 22;
    localparam logic [2:0] RST_CMD = 3'h0;
    localparam logic [4:0] RST_ACK = 5'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [31:0] RST_ERR_STAT = 32'h0000_0001;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : srplm_pkg

`default_nettype wire

// ---- hw/srplm_regs.sv ----
// Link maintenance, ackID, error status and control registers for one port.
// Assumes a single-cycle register port and link logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Command 011 resets device, 100 input status
// - Response bits 4..0 capture link status
// - Response bits 9..5 capture partner_ack_index_state
// - Valid set when awaited response arrives
// - Valid set when responseless request sent
// - Reading response register clears valid bit
// - Next transmit ackID, resets zero, writable
// - Writing transmit ackID triggers resend
// - Expected acknowledge ackID writable
// - Expected receive ackID, resets zero, writable
// - Writing bit 31 discards unacked packets
// - Discard bit is write-only, reads zero
// - Live error status bits hold during PLL reset; sticky bits still set and clear
// - Input stopped bit; sticky input error
// - Input retry-stopped status bit
// - Output stopped bit; sticky output error
// - Output retry, retried, sticky retry bits
// - Resend suppress mask, resets zero
// - Input enable, resets off
// - Output enable and fault check off
module srplm_regs
    import srplm_pkg::*;
#(
    parameter logic [3:0] PORT_INDEX = 4'h0
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic link_req_send,
    output logic [2:0] link_req_cmd,
    input wire logic link_req_sent,
    input wire logic link_resp_valid,
    input wire logic [4:0] link_resp_status,
    input wire logic [4:0] partner_ack_index_state,
    output logic resend_from,
    output logic discard_unacked,
    input wire logic tx_ack_advance,
    input wire logic exp_ack_advance,
    input wire logic rx_ack_advance,
    output logic [4:0] next_tx_ack_index,
    output logic [4:0] expected_ack_index,
    output logic [4:0] next_rx_ack_index,
    input wire logic pll_reset,
    input wire logic port_not_initialised,
    input wire logic port_ok,
    input wire logic port_error_event,
    input wire logic port_write_pending,
    input wire logic input_stopped_err,
    input wire logic input_err_event,
    input wire logic input_stopped_retry,
    input wire logic output_stopped_err,
    input wire logic output_err_event,
    input wire logic output_stopped_retry,
    input wire logic output_retried,
    input wire logic output_retry_event,
    output logic [7:0] resend_suppress_mask,
    output logic input_port_enable,
    output logic output_port_enable,
    output logic fault_check_off
);

    // Per-port register address: offset plus port base
    function automatic logic [ADDR_W-1:0] port_addr(input logic [ADDR_W-1:0] ofs);
        port_addr = ofs + (PORT_STRIDE * {20'h0_0000, PORT_INDEX});
    endfunction : port_addr

    typedef enum logic [1:0]
    {
        SRPLM_IDLE = 2'b00,
        SRPLM_SEND = 2'b01,
        SRPLM_WAIT = 2'b10
    } srplm_req_t;

    srplm_req_t req_state_r;
    logic [2:0] cmd_r;
    logic resp_valid_r;
    logic [4:0] resp_link_r;
    logic [4:0] resp_ack_r;
    logic [4:0] tx_ack_r;
    logic [4:0] exp_ack_r;
    logic [4:0] rx_ack_r;
    logic resend_r;
    logic discard_r;
    logic [31:0] stat_r;
    logic port_err_seen_r;
    logic in_err_seen_r;
    logic out_err_seen_r;
    logic out_retry_seen_r;
    logic [7:0] mask_r;
    logic enum_r;
    logic mcast_r;
    logic chk_off_r;
    logic in_en_r;
    logic out_en_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic sel_req;
    logic sel_resp;
    logic sel_ack;
    logic sel_stat;
    logic sel_ctrl;
    logic cmd_ok;

    assign sel_req = (reg_addr == port_addr(OFS_LINK_REQ));
    assign sel_resp = (reg_addr == port_addr(OFS_LINK_RESP));
    assign sel_ack = (reg_addr == port_addr(OFS_ACKID));
    assign sel_stat = (reg_addr == port_addr(OFS_ERR_STAT));
    assign sel_ctrl = (reg_addr == port_addr(OFS_PORT_CTRL));

    // only the two defined commands start a request; a write in SRPLM_SEND still reloads the command sent
    assign cmd_ok = (reg_wdata[2:0] == CMD_RESET_DEVICE)
        || (reg_wdata[2:0] == CMD_INPUT_STATUS);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            cmd_r <= RST_CMD;
        else if (reg_wr && sel_req)
            cmd_r <= reg_wdata[2:0];
    end

    // one request symbol per valid command write taken in SRPLM_IDLE
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            req_state_r <= SRPLM_IDLE;
        else
        begin
            case (req_state_r)
                SRPLM_IDLE:
                    if (reg_wr && sel_req && cmd_ok)
                        req_state_r <= SRPLM_SEND;
                SRPLM_SEND:
                    if (link_req_sent)
                        req_state_r <= (cmd_r == CMD_INPUT_STATUS) ? SRPLM_WAIT : SRPLM_IDLE;
                SRPLM_WAIT:
                    if (link_resp_valid)
                        req_state_r <= SRPLM_IDLE;
                default:
                    req_state_r <= SRPLM_IDLE;
            endcase
        end
    end

    assign link_req_send = (req_state_r == SRPLM_SEND);
    assign link_req_cmd = cmd_r;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            resp_link_r <= RST_ACK;
            resp_ack_r <= RST_ACK;
        end
        else if (req_state_r == SRPLM_WAIT && link_resp_valid)
        begin
            resp_link_r <= link_resp_status;
            resp_ack_r <= partner_ack_index_state;
        end
    end

    // Set wins over the clear-on-read in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            resp_valid_r <= 1'b0;
        else if (req_state_r == SRPLM_WAIT && link_resp_valid)
            resp_valid_r <= 1'b1;
        else if (req_state_r == SRPLM_SEND && link_req_sent && cmd_r != CMD_INPUT_STATUS)
            resp_valid_r <= 1'b1;
        else if (reg_rd && sel_resp)
            resp_valid_r <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tx_ack_r <= RST_ACK;
        else if (reg_wr && sel_ack)
            tx_ack_r <= reg_wdata[ACK_TX_LSB +: 5];
        else if (tx_ack_advance)
            tx_ack_r <= tx_ack_r + 5'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            exp_ack_r <= RST_ACK;
        else if (reg_wr && sel_ack)
            exp_ack_r <= reg_wdata[ACK_EXP_LSB +: 5];
        else if (exp_ack_advance)
            exp_ack_r <= exp_ack_r + 5'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            rx_ack_r <= RST_ACK;
        else if (reg_wr && sel_ack)
            rx_ack_r <= reg_wdata[ACK_RX_LSB +: 5];
        else if (rx_ack_advance)
            rx_ack_r <= rx_ack_r + 5'h01;
    end

    // resend pulse on transmit ackID write
    // discard pulse on bit 31 write
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            resend_r <= 1'b0;
            discard_r <= 1'b0;
        end
        else
        begin
            resend_r <= reg_wr && sel_ack;
            discard_r <= reg_wr && sel_ack && reg_wdata[ACK_DISCARD_BIT];
        end
    end

    assign resend_from = resend_r;
    assign discard_unacked = discard_r;
    assign next_tx_ack_index = tx_ack_r;
    assign expected_ack_index = exp_ack_r;
    assign next_rx_ack_index = rx_ack_r;

    // Sticky bits: event wins over the write-one clear
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            port_err_seen_r <= 1'b0;
            in_err_seen_r <= 1'b0;
            out_err_seen_r <= 1'b0;
            out_retry_seen_r <= 1'b0;
        end
        else
        begin
            port_err_seen_r <= port_error_event
                || (port_err_seen_r && !(reg_wr && sel_stat && reg_wdata[ES_ERR_BIT]));
            in_err_seen_r <= input_err_event
                || (in_err_seen_r && !(reg_wr && sel_stat && reg_wdata[ES_IN_ERR_SEEN_BIT]));
            out_err_seen_r <= output_err_event
                || (out_err_seen_r && !(reg_wr && sel_stat && reg_wdata[ES_OUT_ERR_SEEN_BIT]));
            out_retry_seen_r <= output_retry_event
                || (out_retry_seen_r && !(reg_wr && sel_stat && reg_wdata[ES_OUT_RETRY_SEEN_BIT]));
        end
    end

    // Live status snapshot; frozen while the PLLs are in reset
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            stat_r <= RST_ERR_STAT;
        else if (!pll_reset)
        begin
            stat_r <= 32'h0000_0000;
            stat_r[ES_UNINIT_BIT] <= port_not_initialised;
            stat_r[ES_OK_BIT] <= port_ok;
            stat_r[ES_PW_BIT] <= port_write_pending;
            stat_r[ES_IN_ERR_BIT] <= input_stopped_err;
            stat_r[ES_IN_RETRY_BIT] <= input_stopped_retry;
            stat_r[ES_OUT_ERR_BIT] <= output_stopped_err;
            stat_r[ES_OUT_RETRY_BIT] <= output_stopped_retry;
            stat_r[ES_OUT_RETRIED_BIT] <= output_retried;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mask_r <= RST_MASK;
            enum_r <= 1'b0;
            mcast_r <= 1'b0;
            chk_off_r <= 1'b0;
            in_en_r <= 1'b0;
            out_en_r <= 1'b0;
        end
        else if (reg_wr && sel_ctrl)
        begin
            mask_r <= reg_wdata[PC_MASK_LSB +: 8];
            enum_r <= reg_wdata[PC_ENUM_BIT];
            mcast_r <= reg_wdata[PC_MCAST_BIT];
            chk_off_r <= reg_wdata[PC_CHK_OFF_BIT];
            in_en_r <= reg_wdata[PC_IN_EN_BIT];
            out_en_r <= reg_wdata[PC_OUT_EN_BIT];
        end
    end

    assign resend_suppress_mask = mask_r;
    assign input_port_enable = in_en_r;
    assign output_port_enable = out_en_r;
    assign fault_check_off = chk_off_r;

    always_comb
    begin
        rdata_nxt = UNMAPPED_DATA;
        if (sel_req)
            rdata_nxt[2:0] = cmd_r;
        else if (sel_resp)
        begin
            rdata_nxt[RESP_LINK_LSB +: 5] = resp_link_r;
            rdata_nxt[RESP_ACK_LSB +: 5] = resp_ack_r;
            rdata_nxt[RESP_VALID_BIT] = resp_valid_r;
        end
        else if (sel_ack)
        begin
            rdata_nxt[ACK_TX_LSB +: 5] = tx_ack_r;
            rdata_nxt[ACK_EXP_LSB +: 5] = exp_ack_r;
            rdata_nxt[ACK_RX_LSB +: 5] = rx_ack_r;
        end
        else if (sel_stat)
        begin
            rdata_nxt = stat_r;
            rdata_nxt[ES_ERR_BIT] = port_err_seen_r;
            rdata_nxt[ES_IN_ERR_SEEN_BIT] = in_err_seen_r;
            rdata_nxt[ES_OUT_ERR_SEEN_BIT] = out_err_seen_r;
            rdata_nxt[ES_OUT_RETRY_SEEN_BIT] = out_retry_seen_r;
        end
        else if (sel_ctrl)
        begin
            rdata_nxt[PC_TYPE_BIT] = 1'b1;
            rdata_nxt[PC_MASK_LSB +: 8] = mask_r;
            rdata_nxt[PC_ENUM_BIT] = enum_r;
            rdata_nxt[PC_MCAST_BIT] = mcast_r;
            rdata_nxt[PC_CHK_OFF_BIT] = chk_off_r;
            rdata_nxt[PC_IN_EN_BIT] = in_en_r;
            rdata_nxt[PC_OUT_EN_BIT] = out_en_r;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            rdata_r <= UNMAPPED_DATA;
        else if (reg_rd)
            rdata_r <= rdata_nxt;
        else
            rdata_r <= UNMAPPED_DATA;
    end

    assign reg_rdata = rdata_r;

endmodule : srplm_regs

`default_nettype wire

// ---- verification/srplm_monitor.sv ----
// Checker for one port's link maintenance registers.
// Assumes it is bound to srplm_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module srplm_monitor
    import srplm_pkg::*;
#(
    parameter logic [3:0] PORT_INDEX = 4'h0
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic link_req_send,
    input wire logic link_req_sent,
    input wire logic resend_from,
    input wire logic discard_unacked,
    input wire logic [4:0] next_tx_ack_index,
    input wire logic [4:0] expected_ack_index,
    input wire logic [4:0] next_rx_ack_index,
    input wire logic [7:0] resend_suppress_mask,
    input wire logic input_port_enable,
    input wire logic output_port_enable,
    input wire logic fault_check_off
);
    logic [23:0] base;
    logic wa;
    logic wq;
    logic wc;
    logic good;
    logic [2:0] ctl_en;
    assign base = PORT_STRIDE * PORT_INDEX;
    assign ctl_en = {output_port_enable, input_port_enable, fault_check_off};
    assign wa = reg_wr && (reg_addr == base + OFS_ACKID);
    assign wq = reg_wr && (reg_addr == base + OFS_LINK_REQ);
    assign wc = reg_wr && (reg_addr == base + OFS_PORT_CTRL);
    assign good = reg_wdata[2:0] inside {CMD_RESET_DEVICE, CMD_INPUT_STATUS};
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    AST_DISC_RD: assert property (reg_rd && reg_addr == base + OFS_ACKID |=> !reg_rdata[31])
        else $error("discard bit read back as one");
    AST_DISC: assert property (wa && reg_wdata[31] |=> discard_unacked)
        else $error("discard pulse missing");
    AST_DISC_WHY: assert property (discard_unacked |-> $past(wa && reg_wdata[31]))
        else $error("discard pulse without cause");
    AST_TX: assert property (wa |=> resend_from && next_tx_ack_index == $past(reg_wdata[4:0]))
        else $error("transmit index or resend wrong");
    AST_EXP: assert property (wa |=> expected_ack_index == $past(reg_wdata[12:8]))
        else $error("expected index not written");
    AST_RX: assert property (wa |=> next_rx_ack_index == $past(reg_wdata[28:24]))
        else $error("receive index not written");
    AST_REQ_WHY: assert property ($rose(link_req_send) |-> $past(wq && good))
        else $error("request raised without command");
    AST_REQ_BAD: assert property (wq && !good && !link_req_send |=> !link_req_send)
        else $error("reserved command sent");
    AST_REQ_HOLD: assert property (link_req_send && !link_req_sent |=> link_req_send)
        else $error("request dropped before sent");
    AST_CTL: assert property (wc |=> resend_suppress_mask == $past(reg_wdata[11:4]))
        else $error("control write not taken");
    AST_CTL_EN: assert property (wc |=> ctl_en == $past(reg_wdata[22:20]))
        else $error("enable or check bits not taken");
    AST_CTL_HOLD: assert property (!wc |=> $stable({output_port_enable, fault_check_off}))
        else $error("control bits moved without write");
endmodule : srplm_monitor
bind srplm_regs srplm_monitor #(.PORT_INDEX(PORT_INDEX)) srplm_monitor_i (.ref_clk, .reset,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_req_send, .link_req_sent,
    .resend_from, .discard_unacked, .next_tx_ack_index, .expected_ack_index,
    .next_rx_ack_index, .resend_suppress_mask, .input_port_enable, .output_port_enable,
    .fault_check_off);
`default_nettype wire

// ---- verification/srplm_link_partner.sv ----
// Behavioural link partner: takes request symbols, answers input status.
// Assumes the same clock as the register bank; dly sets answer speed.
`timescale 1ns/100ps
`default_nettype none
module srplm_link_partner
    import srplm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] dly,
    input wire logic [4:0] st,
    input wire logic [4:0] ak,
    input wire logic link_req_send,
    input wire logic [2:0] link_req_cmd,
    output logic link_req_sent,
    output logic link_resp_valid,
    output logic [4:0] link_resp_status,
    output logic [4:0] partner_ack_index_state
);
    logic [3:0] cnt_r;
    logic wait_r;
    always_ff @(posedge ref_clk)
    begin
        link_req_sent <= 1'b0;
        link_resp_valid <= 1'b0;
        // Idle status lines toggle so stale values cannot pass
        link_resp_status <= ~link_resp_status;
        partner_ack_index_state <= ~partner_ack_index_state;
        if (reset)
        begin
            cnt_r <= 4'h0;
            wait_r <= 1'b0;
            link_resp_status <= 5'h00;
            partner_ack_index_state <= 5'h00;
        end
        else if (link_req_send && !link_req_sent)
        begin
            cnt_r <= (cnt_r == dly) ? 4'h0 : cnt_r + 4'h1;
            link_req_sent <= (cnt_r == dly);
            // only input status earns a response
            wait_r <= (cnt_r == dly) && (link_req_cmd == CMD_INPUT_STATUS);
        end
        else if (wait_r)
        begin
            cnt_r <= (cnt_r == dly) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r == dly)
            begin
                link_resp_valid <= 1'b1;
                link_resp_status <= st;
                partner_ack_index_state <= ak;
                wait_r <= 1'b0;
            end
        end
    end
endmodule : srplm_link_partner
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the register bank of port 2.
// Assumes the package constants and a behavioural link partner.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import srplm_pkg::*;
    ;
    typedef struct packed {logic [23:0] a; logic [31:0] w; logic [31:0] e;} srplm_row_t;
    localparam logic [23:0] B = PORT_STRIDE * 24'h00_0002;
    localparam logic [23:0] A_REQ = B + OFS_LINK_REQ;
    localparam logic [23:0] A_RSP = B + OFS_LINK_RESP;
    localparam logic [23:0] A_ACK = B + OFS_ACKID;
    localparam logic [23:0] A_ERR = B + OFS_ERR_STAT;
    localparam logic [23:0] A_CTL = B + OFS_PORT_CTRL;
    localparam srplm_row_t ROWS [6] = '{
        '{A_CTL, 32'hffff_ffff, 32'h007a_0ff1}, '{A_CTL, 32'h0000_0000, 32'h0000_0001},
        '{A_REQ, 32'h0000_0007, 32'h0000_0007}, '{24'h00_0140, 32'hffff_ffff, 32'h0000_0000},
        '{A_ACK, 32'h1f1f_1f15, 32'h1f00_1f15}, '{A_ACK, 32'h8a00_0a0a, 32'h0a00_0a0a}};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [23:0] reg_addr = 24'h00_0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, pll_reset = 1'b0;
    logic [7:0] live = 8'h80;
    logic [3:0] ev = 4'h0, dly = 4'h0;
    logic [2:0] adv = 3'h0;
    logic [4:0] st = 5'h00, ak = 5'h00;
    logic [31:0] reg_rdata;
    logic [2:0] link_req_cmd;
    logic [4:0] link_resp_status, partner_ack_index_state;
    logic link_req_send, link_req_sent, link_resp_valid;
    int n_fail = 0;
    int n_checks = 0;
    always #50 ref_clk = ~ref_clk;
    srplm_regs #(.PORT_INDEX(4'h2)) srplm_regs_i (.ref_clk, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .link_req_send, .link_req_cmd, .link_req_sent,
        .link_resp_valid, .link_resp_status, .partner_ack_index_state, .resend_from(),
        .discard_unacked(), .tx_ack_advance(adv[2]), .exp_ack_advance(adv[1]),
        .rx_ack_advance(adv[0]), .next_tx_ack_index(), .expected_ack_index(),
        .next_rx_ack_index(), .pll_reset, .port_not_initialised(live[7]), .port_ok(live[6]),
        .port_error_event(ev[3]), .port_write_pending(live[5]), .input_stopped_err(live[4]),
        .input_err_event(ev[2]), .input_stopped_retry(live[3]), .output_stopped_err(live[2]),
        .output_err_event(ev[1]), .output_stopped_retry(live[1]), .output_retried(live[0]),
        .output_retry_event(ev[0]), .resend_suppress_mask(), .input_port_enable(),
        .output_port_enable(), .fault_check_off());
    srplm_link_partner srplm_link_partner_i (.ref_clk, .reset, .dly, .st, .ak,
        .link_req_send, .link_req_cmd, .link_req_sent, .link_resp_valid, .link_resp_status,
        .partner_ack_index_state);
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    // Each access leaves an idle cycle so no strobe is driven twice at one edge
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [23:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        @(posedge ref_clk);
    endtask : rd
    // Selects the response pulse when set, else the symbol-sent pulse
    task automatic wait_for(input logic want_resp);
        for (int i = 0; i < 100; i++)
        begin
            @(posedge ref_clk);
            if ((want_resp ? link_resp_valid : link_req_sent) === 1'b1)
                return;
        end
        n_fail++;
        test_done();
    endtask : wait_for
    task automatic pulse_cycle();
        @(posedge ref_clk);
        ev <= 4'h0;
        adv <= 3'h0;
        @(posedge ref_clk);
    endtask : pulse_cycle
    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(A_REQ, 32'h0000_0000);
        rd(A_RSP, 32'h0000_0000);
        rd(A_ACK, 32'h0000_0000);
        rd(A_ERR, 32'h0000_0001);
        rd(A_CTL, 32'h0000_0001);
        $display("test reset values done");
        foreach (ROWS[k])
        begin
            wr(ROWS[k].a, ROWS[k].w);
            rd(ROWS[k].a, ROWS[k].e);
        end
        $display("test register rows done");
        adv <= 3'h7;
        pulse_cycle();
        rd(A_ACK, 32'h0b00_0b0b);
        $display("test index advance done");
        st <= 5'h15;
        ak <= 5'h0a;
        dly <= 4'h3;
        wr(A_REQ, 32'h0000_0004);
        chk({29'h0000_0000, link_req_cmd}, {29'h0000_0000, CMD_INPUT_STATUS});
        wait_for(1'b1);
        rd(A_RSP, 32'h8000_0155);
        rd(A_RSP, 32'h0000_0155);
        dly <= 4'h0;
        wr(A_REQ, 32'h0000_0003);
        wait_for(1'b0);
        rd(A_RSP, 32'h8000_0155);
        rd(A_RSP, 32'h0000_0155);
        $display("test link request done");
        live <= 8'h7f;
        ev <= 4'hf;
        pulse_cycle();
        rd(A_ERR, 32'h001f_0716);
        wr(A_ERR, 32'h0002_0200);
        rd(A_ERR, 32'h001d_0516);
        pll_reset <= 1'b1;
        live <= 8'h6f;
        @(posedge ref_clk);
        rd(A_ERR, 32'h001d_0516);
        pll_reset <= 1'b0;
        @(posedge ref_clk);
        rd(A_ERR, 32'h001d_0416);
        $display("test error status done");
        wr(A_CTL, 32'h0070_0000);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(A_CTL, 32'h0000_0001);
        rd(A_ACK, 32'h0000_0000);
        $display("test second reset done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
